/* File: rtl/dmbx_core.sv */
`timescale 1ns/1ps
module dmbx_core
  import dmbx_pkg::*;
#(
  parameter logic [15:0] SP_RESET = 16'h0000
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic [15:0] INSTR_EXT,
  output logic INSTR_READY,
  output dmbx_dm_req_t DM_REQ,
  input wire logic [7:0] DM_RDATA,
  output dmbx_io_req_t IO_REQ,
  input wire logic [7:0] IO_RDATA,
  output logic [15:0] PM_ADDR,
  output logic PM_RE,
  input wire logic [7:0] PM_RDATA,
  output logic SLEEP_REQ,
  output logic WDOG_RESTART
);

  initial begin
    if ($bits(SP_RESET) != 16) begin
      $error("Stack pointer reset value must be 16 bits wide.");
    end
  end

  function automatic logic dmbx_match(input logic [15:0] w, input logic [15:0] m,
                                      input logic [15:0] p);
    return (w & m) == p;
  endfunction : dmbx_match

  function automatic logic [4:0] dmbx_rd(input logic [15:0] w);
    return {w[8], w[7:4]};
  endfunction : dmbx_rd

  function automatic logic [4:0] dmbx_rr(input logic [15:0] w);
    return {w[9], w[3:0]};
  endfunction : dmbx_rr

  function automatic logic [5:0] dmbx_q(input logic [15:0] w);
    return {w[13], w[11:10], w[2:0]};
  endfunction : dmbx_q

  function automatic logic [15:0] dmbx_ptr(input dmbx_rf_t rf, input logic [4:0] lo);
    return {rf[lo + 5'h01], rf[lo]};
  endfunction : dmbx_ptr

  function automatic dmbx_rf_t dmbx_set_ptr(input dmbx_rf_t rf, input logic [4:0] lo,
                                            input logic [15:0] v);
    dmbx_rf_t o;
    o = rf;
    o[lo] = v[7:0];
    o[lo + 5'h01] = v[15:8];
    return o;
  endfunction : dmbx_set_ptr

  // Returns carry out above the shifted byte.
  function automatic logic [8:0] dmbx_shift(input logic [2:0] kind, input logic [7:0] v,
                                            input logic c);
    case (kind)
      DMBX_SH_RLC: return {v[7], v[6:0], c};
      DMBX_SH_LSL: return {v[7], v[6:0], 1'b0};
      DMBX_SH_RRC: return {v[0], c, v[7:1]};
      DMBX_SH_LSR: return {v[0], 1'b0, v[7:1]};
      DMBX_SH_ASR: return {v[0], v[7], v[7:1]};
      DMBX_SH_SWAP: return {c, v[3:0], v[7:4]};
      default: return {c, v};
    endcase
  endfunction : dmbx_shift

  function automatic logic [7:0] dmbx_shift_flags(input logic [7:0] f, input logic [8:0] r);
    logic [7:0] o;
    o = f;
    o[DMBX_F_C] = r[8];
    o[DMBX_F_Z] = r[7:0] == 8'h00;
    o[DMBX_F_N] = r[7];
    o[DMBX_F_V] = r[7] ^ r[8];
    return o;
  endfunction : dmbx_shift_flags

  dmbx_state_t s;
  dmbx_state_t next_s;
  dmbx_io_req_t io;
  logic [15:0] w;
  logic [4:0] rd;
  logic [4:0] rr;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] mem_addr;
  logic mem_go;
  logic [8:0] shv;
  logic [7:0] bmask;
  logic acc;

  assign INSTR_READY = (s.phase == DMBX_PH_IDLE) && s.run;
  assign acc = INSTR_VALID && INSTR_READY;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (PADDR != DMBX_OFF_CTRL) &&
                   (PADDR != DMBX_OFF_FLAGS) && (PADDR != DMBX_OFF_SP);
  assign PRDATA = s.prdata;
  assign DM_REQ = s.dm;
  assign IO_REQ = io;
  assign PM_ADDR = s.pm_addr;
  assign PM_RE = s.pm_re;
  assign SLEEP_REQ = s.sleep;
  assign WDOG_RESTART = s.wdog;

  always_comb begin
    next_s = s;
    next_s.dm.we = 1'b0;
    next_s.dm.re = 1'b0;
    next_s.pm_re = 1'b0;
    next_s.sleep = 1'b0;
    next_s.wdog = 1'b0;
    io = '0;
    w = INSTR_WORD;
    rd = dmbx_rd(INSTR_WORD);
    rr = dmbx_rr(INSTR_WORD);
    ptr_lo = DMBX_ZL;
    ptr_val = 16'h0000;
    mem_addr = 16'h0000;
    mem_go = 1'b0;
    shv = 9'h000;
    bmask = 8'h01 << INSTR_WORD[2:0];
    case (s.phase)
      DMBX_PH_IDLE: begin
        if (acc) begin
          if (dmbx_match(w, DMBX_M_MOVE, DMBX_P_MOVE)) begin
            next_s.rf[rd] = s.rf[rr];
          end else if (dmbx_match(w, DMBX_M_IMM, DMBX_P_IMM)) begin
            next_s.rf[{1'b1, w[7:4]}] = {w[11:8], w[3:0]};
          end else if (dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST)) begin
            case (w[3:0])
              DMBX_NIB_DIRECT: begin
                mem_go = 1'b1;
                mem_addr = INSTR_EXT;
              end
              4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd, 4'he: begin
                ptr_lo = (w[3:2] == 2'b11) ? DMBX_XL : (w[3] ? DMBX_YL : DMBX_ZL);
                ptr_val = dmbx_ptr(s.rf, ptr_lo);
                mem_go = 1'b1;
                if (w[1]) begin
                  mem_addr = ptr_val - 16'h0001;
                  next_s.rf = dmbx_set_ptr(s.rf, ptr_lo, mem_addr);
                end else begin
                  mem_addr = ptr_val;
                  if (w[0]) begin
                    next_s.rf = dmbx_set_ptr(s.rf, ptr_lo, ptr_val + 16'h0001);
                  end
                end
              end
              DMBX_NIB_STACK: begin
                mem_go = 1'b1;
                if (w[9]) begin
                  mem_addr = s.sp;
                  next_s.sp = s.sp - 16'h0001;
                end else begin
                  mem_addr = s.sp + 16'h0001;
                  next_s.sp = mem_addr;
                end
              end
              default: begin
                mem_go = 1'b0;
              end
            endcase
          end else if (dmbx_match(w, DMBX_M_DISP, DMBX_P_DISP)) begin
            ptr_lo = w[3] ? DMBX_YL : DMBX_ZL;
            mem_go = 1'b1;
            mem_addr = dmbx_ptr(s.rf, ptr_lo) + {10'h000, dmbx_q(w)};
          end else if (w == DMBX_OP_PMLOAD) begin
            next_s.pm_re = 1'b1;
            next_s.pm_addr = dmbx_ptr(s.rf, DMBX_ZL);
            next_s.phase = DMBX_PH_PM1;
          end else if (dmbx_match(w, DMBX_M_IO, DMBX_P_IO)) begin
            io.addr = {w[10:9], w[3:0]};
            if (w[11]) begin
              io.we = 1'b1;
              io.wdata = s.rf[rd];
            end else begin
              io.re = 1'b1;
              next_s.rf[rd] = IO_RDATA;
            end
          end else if (dmbx_match(w, DMBX_M_IOBIT, DMBX_P_IOBIT)) begin
            io.re = 1'b1;
            io.addr = {1'b0, w[7:3]};
            next_s.io_addr = {1'b0, w[7:3]};
            next_s.io_val = w[9] ? (IO_RDATA | bmask) : (IO_RDATA & ~bmask);
            next_s.phase = DMBX_PH_IOBIT;
          end else if ((dmbx_match(w, DMBX_M_TWO, DMBX_P_ADC) ||
                        dmbx_match(w, DMBX_M_TWO, DMBX_P_ADD)) && (rd == rr)) begin
            shv = dmbx_shift(w[12] ? DMBX_SH_RLC : DMBX_SH_LSL, s.rf[rd], s.status_register[DMBX_F_C]);
            next_s.rf[rd] = shv[7:0];
            next_s.status_register = dmbx_shift_flags(s.status_register, shv);
          end else if (dmbx_match(w, DMBX_M_ONE, DMBX_P_ONE) &&
                       ((w[2:0] == DMBX_SH_SWAP) || w[2])) begin
            shv = dmbx_shift(w[2:0], s.rf[rd], s.status_register[DMBX_F_C]);
            next_s.rf[rd] = shv[7:0];
            if (w[2:0] != DMBX_SH_SWAP) begin
              next_s.status_register = dmbx_shift_flags(s.status_register, shv);
            end
          end else if (dmbx_match(w, DMBX_M_FLAG, DMBX_P_FLAG)) begin
            next_s.status_register[w[6:4]] = !w[7];
          end else if (dmbx_match(w, DMBX_M_TBIT, DMBX_P_TBIT)) begin
            if (w[9]) begin
              next_s.status_register[DMBX_F_T] = s.rf[rd][w[2:0]];
            end else begin
              next_s.rf[rd][w[2:0]] = s.status_register[DMBX_F_T];
            end
          end else if (w == DMBX_OP_SLEEP) begin
            next_s.sleep = 1'b1;
          end else if (w == DMBX_OP_WDOG) begin
            next_s.wdog = 1'b1;
          end
          if (mem_go) begin
            next_s.dm.addr = mem_addr;
            next_s.dm.we = w[9];
            next_s.dm.re = !w[9];
            next_s.dm.wdata = s.rf[rd];
            next_s.dst = rd;
            next_s.phase = DMBX_PH_MEM;
          end
        end
      end
      DMBX_PH_MEM: begin
        if (s.dm.re) begin
          next_s.rf[s.dst] = DM_RDATA;
        end
        next_s.phase = DMBX_PH_IDLE;
      end
      DMBX_PH_PM1: begin
        next_s.pm_re = 1'b1;
        next_s.phase = DMBX_PH_PM2;
      end
      DMBX_PH_PM2: begin
        next_s.rf[DMBX_R0] = PM_RDATA;
        next_s.phase = DMBX_PH_IDLE;
      end
      DMBX_PH_IOBIT: begin
        io.we = 1'b1;
        io.addr = s.io_addr;
        io.wdata = s.io_val;
        next_s.phase = DMBX_PH_IDLE;
      end
      default: begin
        next_s.phase = DMBX_PH_IDLE;
      end
    endcase
    if (PSEL && !PENABLE) begin
      next_s.prdata = 32'h0000_0000;
      case (PADDR)
        DMBX_OFF_CTRL: next_s.prdata[DMBX_CTRL_RUN] = s.run;
        DMBX_OFF_FLAGS: begin
          next_s.prdata[7:0] = s.status_register;
          next_s.prdata[DMBX_FLAGS_BUSY] = s.phase != DMBX_PH_IDLE;
        end
        DMBX_OFF_SP: next_s.prdata[15:0] = s.sp;
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
    if (PSEL && PENABLE && PWRITE && (PADDR == DMBX_OFF_CTRL)) begin
      next_s.run = PWDATA[DMBX_CTRL_RUN];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
      s.run <= DMBX_RUN_RST;
      s.status_register <= DMBX_STATUS_RST;
      s.sp <= SP_RESET;
      s.phase <= DMBX_PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Snapshot of the previous cycle, read only by the checks below.
  dmbx_state_t prev;
  logic [15:0] prev_w;
  logic [15:0] prev_ext;
  logic [4:0] prd;
  assign prd = dmbx_rd(prev_w);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev <= '0;
      prev_w <= 16'h0000;
      prev_ext <= 16'h0000;
    end else begin
      prev <= s;
      prev_w <= INSTR_WORD;
      prev_ext <= INSTR_EXT;
    end
  end

  default clocking dmbx_cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_load_done;
    DM_REQ.re && !DM_REQ.we ##1
      (s.phase == DMBX_PH_IDLE && s.rf[prev.dst] == $past(DM_RDATA) && s.status_register == prev.status_register);
  endsequence

  sequence s_store_done;
    DM_REQ.we && DM_REQ.wdata == prev.rf[prd] && s.status_register == prev.status_register ##1
      (s.phase == DMBX_PH_IDLE && !DM_REQ.we);
  endsequence

  property p_ld_post;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && !w[9] && w[3:0] == 4'hd && rd < DMBX_XL
    |=> DM_REQ.addr == dmbx_ptr(prev.rf, DMBX_XL) &&
        dmbx_ptr(s.rf, DMBX_XL) == DM_REQ.addr + 16'h0001 ##0 s_load_done;
  endproperty
  a_ld_post: assert property (p_ld_post) else $error("Post-increment load wrong.");

  property p_ld_pre;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && !w[9] && w[3:0] == 4'he && rd < DMBX_XL
    |=> DM_REQ.addr == dmbx_ptr(prev.rf, DMBX_XL) - 16'h0001 &&
        dmbx_ptr(s.rf, DMBX_XL) == DM_REQ.addr ##0 s_load_done;
  endproperty
  a_ld_pre: assert property (p_ld_pre) else $error("Pre-decrement load wrong.");

  property p_ld_disp;
    acc && dmbx_match(w, DMBX_M_DISP, DMBX_P_DISP) && !w[9] && w[3]
    |=> DM_REQ.addr == dmbx_ptr(prev.rf, DMBX_YL) + {10'h000, dmbx_q(prev_w)} &&
        dmbx_ptr(s.rf, DMBX_YL) == dmbx_ptr(prev.rf, DMBX_YL) ##0 s_load_done;
  endproperty
  a_ld_disp: assert property (p_ld_disp) else $error("Displaced load wrong.");

  property p_ld_direct;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && !w[9] && w[3:0] == DMBX_NIB_DIRECT
    |=> DM_REQ.addr == prev_ext ##0 s_load_done;
  endproperty
  a_ld_direct: assert property (p_ld_direct) else $error("Direct load wrong.");

  property p_st_post;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && w[9] && w[3:0] == 4'hd && rd < DMBX_XL
    |=> DM_REQ.addr == dmbx_ptr(prev.rf, DMBX_XL) &&
        dmbx_ptr(s.rf, DMBX_XL) == DM_REQ.addr + 16'h0001 ##0 s_store_done;
  endproperty
  a_st_post: assert property (p_st_post) else $error("Post-increment store wrong.");

  property p_st_direct;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && w[9] && w[3:0] == DMBX_NIB_DIRECT
    |=> DM_REQ.addr == prev_ext ##0 s_store_done;
  endproperty
  a_st_direct: assert property (p_st_direct) else $error("Direct store wrong.");

  property p_push;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && w[9] && w[3:0] == DMBX_NIB_STACK
    |=> DM_REQ.addr == prev.sp && s.sp == prev.sp - 16'h0001 ##0 s_store_done;
  endproperty
  a_push: assert property (p_push) else $error("Push wrong.");

  property p_pop;
    acc && dmbx_match(w, DMBX_M_LDST, DMBX_P_LDST) && !w[9] && w[3:0] == DMBX_NIB_STACK
    |=> DM_REQ.addr == prev.sp + 16'h0001 && s.sp == DM_REQ.addr ##0 s_load_done;
  endproperty
  a_pop: assert property (p_pop) else $error("Pop wrong.");

  property p_iobit;
    acc && dmbx_match(w, DMBX_M_IOBIT, DMBX_P_IOBIT)
    |=> IO_REQ.we && IO_REQ.addr == {1'b0, prev_w[7:3]} &&
        IO_REQ.wdata[prev_w[2:0]] == prev_w[9] && s.status_register == prev.status_register ##1 INSTR_READY;
  endproperty
  a_iobit: assert property (p_iobit) else $error("I/O bit write wrong.");

  property p_rol;
    acc && dmbx_match(w, DMBX_M_TWO, DMBX_P_ADC) && rd == rr
    |=> s.rf[prd] == {prev.rf[prd][6:0], prev.status_register[DMBX_F_C]} &&
        s.status_register[DMBX_F_C] == prev.rf[prd][7] &&
        s.status_register[DMBX_F_V] == (s.status_register[DMBX_F_N] ^ s.status_register[DMBX_F_C]) && INSTR_READY;
  endproperty
  a_rol: assert property (p_rol) else $error("Rotate left wrong.");

  property p_ror;
    acc && dmbx_match(w, DMBX_M_ONE, DMBX_P_ONE) && w[2:0] == DMBX_SH_RRC
    |=> s.rf[prd] == {prev.status_register[DMBX_F_C], prev.rf[prd][7:1]} &&
        s.status_register[DMBX_F_C] == prev.rf[prd][0] && s.status_register[DMBX_F_Z] == (s.rf[prd] == 8'h00);
  endproperty
  a_ror: assert property (p_ror) else $error("Rotate right wrong.");

  property p_bst;
    acc && dmbx_match(w, DMBX_M_TBIT, DMBX_P_TBIT) && w[9]
    |=> s.status_register[DMBX_F_T] == prev.rf[prd][prev_w[2:0]] &&
        ((s.status_register ^ prev.status_register) & ~(8'h01 << DMBX_F_T)) == 8'h00;
  endproperty
  a_bst: assert property (p_bst) else $error("Bit store wrong.");

  property p_bld;
    acc && dmbx_match(w, DMBX_M_TBIT, DMBX_P_TBIT) && !w[9]
    |=> s.rf[prd][prev_w[2:0]] == prev.status_register[DMBX_F_T] && s.status_register == prev.status_register;
  endproperty
  a_bld: assert property (p_bld) else $error("Bit load wrong.");

  property p_flag;
    acc && dmbx_match(w, DMBX_M_FLAG, DMBX_P_FLAG)
    |=> s.status_register[prev_w[6:4]] == !prev_w[7] &&
        ((s.status_register ^ prev.status_register) & ~(8'h01 << prev_w[6:4])) == 8'h00 && INSTR_READY;
  endproperty
  a_flag: assert property (p_flag) else $error("Flag set or clear wrong.");

  property p_sleep;
    acc && w == DMBX_OP_SLEEP |=> SLEEP_REQ && s.status_register == prev.status_register ##1 !SLEEP_REQ;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep request wrong.");

  property p_move;
    acc && dmbx_match(w, DMBX_M_MOVE, DMBX_P_MOVE)
    |=> s.rf[prd] == prev.rf[dmbx_rr(prev_w)] && s.status_register == prev.status_register && INSTR_READY;
  endproperty
  a_move: assert property (p_move) else $error("Register move wrong.");

  property p_pmload;
    acc && w == DMBX_OP_PMLOAD
    |=> PM_RE[*2] ##1 (!PM_RE && s.rf[DMBX_R0] == $past(PM_RDATA) && INSTR_READY);
  endproperty
  a_pmload: assert property (p_pmload) else $error("Program memory load wrong.");

endmodule : dmbx_core

/* File: rtl/dmbx_pkg.sv */
package dmbx_pkg;
  localparam logic [11:0] DMBX_OFF_CTRL = 12'h000;
  localparam logic [11:0] DMBX_OFF_FLAGS = 12'h004;
  localparam logic [11:0] DMBX_OFF_SP = 12'h008;
  localparam int unsigned DMBX_CTRL_RUN = 0;
  localparam int unsigned DMBX_FLAGS_BUSY = 8;
  localparam logic DMBX_RUN_RST = 1'b1;
  localparam logic [7:0] DMBX_STATUS_RST = 8'h00;
  localparam int unsigned DMBX_F_C = 0;
  localparam int unsigned DMBX_F_Z = 1;
  localparam int unsigned DMBX_F_N = 2;
  localparam int unsigned DMBX_F_V = 3;
  localparam int unsigned DMBX_F_T = 6;
  localparam logic [4:0] DMBX_R0 = 5'h00;
  localparam logic [4:0] DMBX_XL = 5'h1a;
  localparam logic [4:0] DMBX_YL = 5'h1c;
  localparam logic [4:0] DMBX_ZL = 5'h1e;
  localparam logic [15:0] DMBX_M_MOVE = 16'hfc00;
  localparam logic [15:0] DMBX_P_MOVE = 16'h2c00;
  localparam logic [15:0] DMBX_M_IMM = 16'hf000;
  localparam logic [15:0] DMBX_P_IMM = 16'he000;
  localparam logic [15:0] DMBX_M_LDST = 16'hfc00;
  localparam logic [15:0] DMBX_P_LDST = 16'h9000;
  localparam logic [15:0] DMBX_M_DISP = 16'hd000;
  localparam logic [15:0] DMBX_P_DISP = 16'h8000;
  localparam logic [15:0] DMBX_M_IO = 16'hf000;
  localparam logic [15:0] DMBX_P_IO = 16'hb000;
  localparam logic [15:0] DMBX_M_IOBIT = 16'hfd00;
  localparam logic [15:0] DMBX_P_IOBIT = 16'h9800;
  localparam logic [15:0] DMBX_M_TWO = 16'hfc00;
  localparam logic [15:0] DMBX_P_ADC = 16'h1c00;
  localparam logic [15:0] DMBX_P_ADD = 16'h0c00;
  localparam logic [15:0] DMBX_M_ONE = 16'hfe08;
  localparam logic [15:0] DMBX_P_ONE = 16'h9400;
  localparam logic [15:0] DMBX_M_FLAG = 16'hff0f;
  localparam logic [15:0] DMBX_P_FLAG = 16'h9408;
  localparam logic [15:0] DMBX_M_TBIT = 16'hfc08;
  localparam logic [15:0] DMBX_P_TBIT = 16'hf800;
  localparam logic [15:0] DMBX_OP_PMLOAD = 16'h95c8;
  localparam logic [15:0] DMBX_OP_SLEEP = 16'h9588;
  localparam logic [15:0] DMBX_OP_WDOG = 16'h95a8;
  localparam logic [3:0] DMBX_NIB_DIRECT = 4'h0;
  localparam logic [3:0] DMBX_NIB_STACK = 4'hf;
  localparam logic [2:0] DMBX_SH_RLC = 3'h0;
  localparam logic [2:0] DMBX_SH_LSL = 3'h1;
  localparam logic [2:0] DMBX_SH_SWAP = 3'h2;
  localparam logic [2:0] DMBX_SH_ASR = 3'h5;
  localparam logic [2:0] DMBX_SH_LSR = 3'h6;
  localparam logic [2:0] DMBX_SH_RRC = 3'h7;
  typedef logic [31:0][7:0] dmbx_rf_t;
  typedef enum logic [2:0] {DMBX_PH_IDLE, DMBX_PH_MEM, DMBX_PH_PM1, DMBX_PH_PM2,
                            DMBX_PH_IOBIT} dmbx_phase_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dmbx_dm_req_t;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dmbx_io_req_t;
  typedef struct packed {
    dmbx_rf_t rf;
    logic [7:0] status_register;
    logic [15:0] sp;
    logic run;
    dmbx_phase_t phase;
    logic [4:0] dst;
    logic [5:0] io_addr;
    logic [7:0] io_val;
    dmbx_dm_req_t dm;
    logic [15:0] pm_addr;
    logic pm_re;
    logic sleep;
    logic wdog;
    logic [31:0] prdata;
  } dmbx_state_t;
endpackage : dmbx_pkg

/* File: bench/dmbx_far_model.sv */
`timescale 1ns/1ps
module dmbx_far_model
  import dmbx_pkg::*;
(
  input wire logic CLK,
  input wire dmbx_dm_req_t DM_REQ,
  output logic [7:0] DM_RDATA,
  input wire dmbx_io_req_t IO_REQ,
  output logic [7:0] IO_RDATA,
  input wire logic [15:0] PM_ADDR,
  input wire logic PM_RE,
  output logic [7:0] PM_RDATA,
  output logic [15:0] last_addr,
  output logic [7:0] last_data
);
  logic [7:0] mem [0:1023];
  logic [7:0] io [0:63];
  // Reads answer in the request cycle; an idle bus shows a moving pattern.
  assign DM_RDATA = DM_REQ.re ? mem[DM_REQ.addr[9:0]] : ~DM_REQ.addr[7:0];
  assign IO_RDATA = IO_REQ.re ? io[IO_REQ.addr] : ~IO_REQ.wdata;
  assign PM_RDATA = PM_RE ? (PM_ADDR[7:0] ^ 8'h3c) : ~PM_ADDR[7:0];
  always @(posedge CLK) begin
    if (DM_REQ.we) begin
      mem[DM_REQ.addr[9:0]] <= DM_REQ.wdata;
      last_addr <= DM_REQ.addr;
      last_data <= DM_REQ.wdata;
    end
    if (IO_REQ.we) io[IO_REQ.addr] <= IO_REQ.wdata;
  end
endmodule : dmbx_far_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import dmbx_pkg::*;
  localparam logic [15:0] SP0 = 16'h025f;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ivalid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, iready, sleep_req, pm_re;
  logic [15:0] iword = 16'h0, iext = 16'h0, pm_addr, last_addr;
  logic [7:0] dm_rdata, io_rdata, pm_rdata, last_data;
  dmbx_dm_req_t dm_req;
  dmbx_io_req_t io_req;
  int failures = 0;
  int samples_checked = 0;
  int sleeps = 0;
  always #2 clk = ~clk;
  always @(negedge clk) if (sleep_req === 1'b1) sleeps++;
  dmbx_core #(.SP_RESET(SP0)) dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INSTR_VALID(ivalid), .INSTR_WORD(iword),
    .INSTR_EXT(iext), .INSTR_READY(iready), .DM_REQ(dm_req), .DM_RDATA(dm_rdata),
    .IO_REQ(io_req), .IO_RDATA(io_rdata), .PM_ADDR(pm_addr), .PM_RE(pm_re),
    .PM_RDATA(pm_rdata), .SLEEP_REQ(sleep_req), .WDOG_RESTART());
  dmbx_far_model fm (.CLK(clk), .DM_REQ(dm_req), .DM_RDATA(dm_rdata), .IO_REQ(io_req),
    .IO_RDATA(io_rdata), .PM_ADDR(pm_addr), .PM_RE(pm_re), .PM_RDATA(pm_rdata),
    .last_addr(last_addr), .last_data(last_data));
  task automatic test_done();
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (!wr) chk("read data", prdata, d);
    chk("slave error", {31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Offers one instruction and counts the cycles until intake reopens.
  task automatic ex(input logic [15:0] w, input logic [15:0] e, input int cyc);
    int n;
    @(posedge clk);
    ivalid <= 1'b1;
    iword <= w;
    iext <= e;
    @(posedge clk);
    ivalid <= 1'b0;
    n = 1;
    @(negedge clk);
    while (iready !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    chk("cycles", n, cyc);
  endtask : ex
  task automatic mc(input logic [15:0] a, input logic [7:0] d);
    chk("memory write", {8'h00, last_addr, last_data}, {8'h00, a, d});
  endtask : mc
  function automatic logic [15:0] li(input logic [4:0] r, input logic [7:0] k);
    return {4'he, k[7:4], r[3:0], k[3:0]};
  endfunction : li
  // Stores a register to a fixed direct address and checks what arrived.
  task automatic st(input logic [4:0] r, input logic [7:0] d);
    ex({7'h49, r, 4'h0}, 16'h0300, 2);
    mc(16'h0300, d);
  endtask : st
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, DMBX_OFF_SP, {16'h0, SP0}, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 1'b1);
    apb(1'b1, DMBX_OFF_CTRL, 32'h0, 1'b0);
    @(negedge clk);
    chk("intake while stopped", {31'h0, iready}, 32'h0);
    apb(1'b1, DMBX_OFF_CTRL, 32'h1, 1'b0);
    ex(li(5'd26, 8'h10), 16'h0, 1);
    ex(li(5'd27, 8'h02), 16'h0, 1);
    ex(li(5'd16, 8'ha5), 16'h0, 1);
    ex(li(5'd17, 8'h3c), 16'h0, 1);
    ex(16'h930d, 16'h0, 2);
    ex(16'h931d, 16'h0, 2);
    mc(16'h0211, 8'h3c);
    ex(16'h912e, 16'h0, 2);
    ex(16'h913e, 16'h0, 2);
    ex(16'h914d, 16'h0, 2);
    ex(16'h932e, 16'h0, 2);
    mc(16'h0210, 8'h3c);
    st(5'd18, 8'h3c);
    st(5'd19, 8'ha5);
    st(5'd20, 8'ha5);
    ex({7'h48, 5'd23, 4'h0}, 16'h0211, 2);
    st(5'd23, 8'h3c);
    ex(li(5'd28, 8'h20), 16'h0, 1);
    ex(li(5'd29, 8'h02), 16'h0, 1);
    ex(16'h830d, 16'h0, 2);
    mc(16'h0225, 8'ha5);
    ex(16'h816d, 16'h0, 2);
    ex(16'h9319, 16'h0, 2);
    mc(16'h0220, 8'h3c);
    st(5'd22, 8'ha5);
    ex(16'h931f, 16'h0, 2);
    mc(SP0, 8'h3c);
    apb(1'b0, DMBX_OFF_SP, {16'h0, SP0 - 16'h1}, 1'b0);
    ex(16'h918f, 16'h0, 2);
    apb(1'b0, DMBX_OFF_SP, {16'h0, SP0}, 1'b0);
    st(5'd24, 8'h3c);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h0, 1'b0);
    ex(16'hb905, 16'h0, 1);
    ex(16'h9a2b, 16'h0, 2);
    chk("io after set", {24'h0, fm.io[5]}, 32'had);
    ex(16'h9828, 16'h0, 2);
    ex(16'hb195, 16'h0, 1);
    st(5'd25, 8'hac);
    ex(16'h2f50, 16'h0, 1);
    st(5'd21, 8'ha5);
    ex(16'h9438, 16'h0, 1);
    ex(16'h9458, 16'h0, 1);
    ex(16'h9448, 16'h0, 1);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h38, 1'b0);
    ex(16'h94b8, 16'h0, 1);
    ex(16'h94d8, 16'h0, 1);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h10, 1'b0);
    ex(16'h94c8, 16'h0, 1);
    ex(16'hfb00, 16'h0, 1);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h40, 1'b0);
    ex(16'hf936, 16'h0, 1);
    st(5'd19, 8'he5);
    ex(li(5'd20, 8'h81), 16'h0, 1);
    ex(16'h9408, 16'h0, 1);
    ex(16'h1f44, 16'h0, 1);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h49, 1'b0);
    st(5'd20, 8'h03);
    ex(16'h9547, 16'h0, 1);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h45, 1'b0);
    st(5'd20, 8'h81);
    ex(li(5'd30, 8'h34), 16'h0, 1);
    ex(li(5'd31, 8'h00), 16'h0, 1);
    ex(DMBX_OP_PMLOAD, 16'h0, 3);
    st(5'd0, 8'h08);
    ex(DMBX_OP_SLEEP, 16'h0, 1);
    @(negedge clk);
    chk("sleep pulses", sleeps, 32'h1);
    apb(1'b0, DMBX_OFF_FLAGS, 32'h45, 1'b0);
    test_done();
  end
endmodule : tb_top
